// ---- verilog/reset_seq_map.vh ----
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the reset sequencer and its bench
`ifndef RESET_SEQ_MAP_VH
`define RESET_SEQ_MAP_VH

`define BROWNOUT_CONTROL_REG_OFS 12'h000
`define POWER_CONTROL_REG_OFS    12'h004
`define STATUS_FLAGS_REG_OFS     12'h008
`define MISC_CONTROL_REG_OFS     12'h00c

`define BOC_SW_ENABLE_BIT   7
`define BOC_FAST_START_BIT  6
`define BOC_READY_BIT       0
`define BOC_RESET_VAL       8'h80

`define POWER_CONTROL_REG_STACK_OVERFLOW_FLAG_BIT     7
`define POWER_CONTROL_REG_STACK_UNDERFLOW_FLAG_BIT     6
`define POWER_CONTROL_REG_WDT_BIT        4
`define POWER_CONTROL_REG_PIN_BIT        3
`define POWER_CONTROL_REG_RI_BIT         2
`define POWER_CONTROL_REG_POR_BIT        1
`define POWER_CONTROL_REG_BOR_BIT        0
`define POWER_CONTROL_REG_POR_VAL        8'h1c

`define STAT_TO_BIT         1
`define STAT_PD_BIT         0

`define MISC_PULLUP_BIT     0

`define MODE_ALWAYS_ON      2'h3
`define MODE_SLEEP_OFF      2'h2
`define MODE_SOFTWARE       2'h1
`define MODE_OFF            2'h0

`define CLK_PERIOD_NS       4
`define POWERUP_TIMER_TIME_MS        64
`define POWERUP_TIMER_CYCLES         ((`POWERUP_TIMER_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define PIN_START_CYCLES    10
`define PIN_FILTER_CYCLES   4

`endif

// ---- verilog/reset_filter.v ----
// Glitch filter: output follows input only after it is stable for N cycles
// Assumes a synchronised input on the same clock
`timescale 1ns/100ps

module reset_filter #(
  parameter N = 4
) (
  input  wire hclk,
  input  wire hresetn,
  input  wire din,
  output reg  dout_q
);
  reg [7:0] cnt_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= 8'h00;
      dout_q <= 1'b1;
    end else if (din == dout_q) begin
      cnt_q <= 8'h00;
    end else if (cnt_q == N[7:0] - 8'h01) begin
      cnt_q  <= 8'h00;
      dout_q <= din;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // reset_filter

// ---- verilog/reset_source_sequencer.v ----
// Reset source combiner, start-up sequencer and reset-cause flags
// Assumes analog comparators, pin and CPU events arrive unsynchronised
//
// How it works
// R1: Mode 11: detector on, start waits ready
// R2: Always-on: active in sleep, no wake delay
// R3: Mode 10: detector off in sleep, start waits
// R4: Mode 10: wake waits detector ready
// R5: Mode 01: software bit enables, no start wait
// R6: Software mode: protect when ready, ignore sleep
// R7: Software enable acts only in mode 01
// R8: Fast-start forces band gap in 10/01
// R9: Ready bit reads detector active state
// R10: Low-power detector resets, clears brown-out flag
// R11: Low-power detector enabled by config bit only
// R12: Pin reset off only if both bits 0
// R13: Pin low holds reset, filter drops glitches
// R14: Never drive reset pin low
// R15: Disabled pin: input with software pull-up
// R16: Watchdog timeout resets, updates timeout/powerdown flags
// R17: Reset instruction resets, clears its flag
// R18: Stack error resets only when enabled, flagged
// R19: Programming exit acts as power-on reset
// R20: Start after timer done and pin released
// R21: Timer independent of pin; 10 cycles after
// R22: Flags per cause; program counter restarts zero
// R23: Power-up timer holds 64 ms
// R24: Power-on/brown-out flags stay 0 till written
// R25: Sources combined, sync assert, sync release
`timescale 1ns/100ps
`include "reset_seq_map.vh"

module reset_source_sequencer #(
  parameter POWERUP_TIMER_CYCLES = `POWERUP_TIMER_CYCLES
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [1:0]  brownout_mode_sel,
  input  wire        low_power_brownout,
  input  wire        ext_reset_pin_enable,
  input  wire        low_voltage_prog,
  input  wire        powerup_timer_enable_n,
  input  wire        stack_err_reset_enable,
  input  wire        por_event,
  input  wire        vdd_low,
  input  wire        lp_vdd_low,
  input  wire        detector_ready,
  input  wire        ext_reset_pin_in,
  input  wire        sleep_mode,
  input  wire        wake_request,
  input  wire        watchdog_timeout,
  input  wire        reset_instr,
  input  wire        stack_overflow,
  input  wire        stack_underflow,
  input  wire        prog_mode_exit,
  output reg         core_reset_n_q,
  output reg         wake_ok_q,
  output reg         detector_enable_q,
  output reg         bandgap_force_q,
  output reg         pin_pullup_q,
  output reg         ext_reset_pin_out,
  output reg         ext_reset_pin_oe,
  output reg         gp_input_q,
  output reg  [13:0] pc_reset_value
);

  localparam ST_HOLD  = 4'b0001;
  localparam ST_TIMER = 4'b0010;
  localparam ST_PIN   = 4'b0100;
  localparam ST_RUN   = 4'b1000;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam NS = 12;
  wire [NS-1:0] raw = {ext_reset_pin_in,
                       vdd_low,
                       lp_vdd_low,
                       detector_ready,
                       sleep_mode,
                       wake_request,
                       watchdog_timeout,
                       reset_instr,
                       stack_overflow,
                       stack_underflow,
                       prog_mode_exit,
                       por_event};
  reg  [NS-1:0] s1_q;
  reg  [NS-1:0] s2_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= {1'b1, {(NS-1){1'b0}}};
      s2_q <= {1'b1, {(NS-1){1'b0}}};
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  wire pin_s    = s2_q[11];
  wire vlow_s   = s2_q[10];
  wire lplow_s  = s2_q[9];
  wire rdy_s    = s2_q[8];
  wire sleep_s  = s2_q[7];
  wire wake_s   = s2_q[6];
  wire wdt_s    = s2_q[5];
  wire ri_s     = s2_q[4];
  wire ovf_s    = s2_q[3];
  wire unf_s    = s2_q[2];
  wire pexit_s  = s2_q[1];
  wire por_s    = s2_q[0];

  ////////////////////////////////////////////////////////////////////////
  // Pin filter
  wire pin_f;
  reset_filter #(
    .N (`PIN_FILTER_CYCLES)
  ) u_pin_filter (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (pin_s),
    .dout_q  (pin_f)
  );                                                   // [R13]

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg        sw_brownout_enable;
  reg        brownout_fast_start;
  reg  [7:0] power_control_reg;
  reg        timeout_flag_n;
  reg        powerdown_flag_n;
  reg        pullup_q;

  wire pin_en = ext_reset_pin_enable | low_voltage_prog;         // [R12]
  wire mode_on    = (brownout_mode_sel == `MODE_ALWAYS_ON);
  wire mode_nosl  = (brownout_mode_sel == `MODE_SLEEP_OFF);
  wire mode_sw    = (brownout_mode_sel == `MODE_SOFTWARE);
  wire det_en = mode_on                                          // [R1] [R2]
              | (mode_nosl & ~sleep_s)                           // [R3]
              | (mode_sw & sw_brownout_enable);                  // [R5] [R6] [R7]
  wire det_active = det_en & rdy_s;                              // [R9]
  wire bor_trip = det_active & vlow_s;                           // [R6]
  wire lp_trip  = low_power_brownout & lplow_s;                  // [R10] [R11]
  wire stk_trip = stack_err_reset_enable & (ovf_s | unf_s);      // [R18]
  wire por_any  = por_s | pexit_s;                               // [R19]
  wire pin_hold = pin_en & ~pin_f;                               // [R13]
  wire start_wait = (mode_on | mode_nosl) & (~rdy_s | vlow_s);   // [R1] [R3]
  wire hard_src = por_any | bor_trip | lp_trip;
  wire any_src  = hard_src | pin_hold | wdt_s | ri_s | stk_trip; // [R25]

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  reg        wr_pend_q;
  reg  [11:0] addr_q;
  wire       take = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 12'h000;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= take & hwrite;
      if (take) begin
        addr_q <= haddr;
      end
      if (take & ~hwrite) begin
        case (haddr)
          `BROWNOUT_CONTROL_REG_OFS: hrdata <= {24'h0, sw_brownout_enable,
                                                 brownout_fast_start, 5'h00, det_active}; // [R9]
          `POWER_CONTROL_REG_OFS:    hrdata <= {24'h0, power_control_reg};
          `STATUS_FLAGS_REG_OFS:     hrdata <= {30'h0, timeout_flag_n, powerdown_flag_n};
          `MISC_CONTROL_REG_OFS:     hrdata <= {31'h0, pullup_q};
          default:                   hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  wire wr_boc  = wr_pend_q & (addr_q == `BROWNOUT_CONTROL_REG_OFS);
  wire wr_power_control_reg = wr_pend_q & (addr_q == `POWER_CONTROL_REG_OFS);
  wire wr_stat = wr_pend_q & (addr_q == `STATUS_FLAGS_REG_OFS);
  wire wr_misc = wr_pend_q & (addr_q == `MISC_CONTROL_REG_OFS);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  reg [3:0]  state_q;
  reg [3:0]  state_d;
  reg [31:0] tmr_q;
  reg [3:0]  gap_q;
  reg        tmr_done_q;
  reg        was_hard_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_q      <= 32'h00000000;
      tmr_done_q <= 1'b0;
      was_hard_q <= 1'b1;
    end else if (hard_src) begin
      tmr_q      <= 32'h00000000;
      tmr_done_q <= 1'b0;
      was_hard_q <= 1'b1;
    end else if (was_hard_q & ~tmr_done_q) begin
      if (powerup_timer_enable_n | (tmr_q == POWERUP_TIMER_CYCLES - 1)) begin    // [R23]
        tmr_done_q <= 1'b1;                                             // [R21]
      end else begin
        tmr_q <= tmr_q + 32'h00000001;
      end
    end else if (state_q == ST_RUN) begin
      was_hard_q <= 1'b0;
    end
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_HOLD: begin
        if (!any_src) begin
          state_d = was_hard_q ? ST_TIMER : ST_PIN;
        end
      end
      ST_TIMER: begin
        if (any_src) begin
          state_d = ST_HOLD;
        end else if (tmr_done_q & ~start_wait) begin
          state_d = ST_PIN;                                      // [R20]
        end
      end
      ST_PIN: begin
        if (any_src) begin
          state_d = ST_HOLD;
        end else if (gap_q == `PIN_START_CYCLES - 1) begin
          state_d = ST_RUN;                                      // [R21]
        end
      end
      ST_RUN: begin
        if (any_src) begin
          state_d = ST_HOLD;
        end
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q        <= ST_HOLD;
      gap_q          <= 4'h0;
      core_reset_n_q <= 1'b0;
    end else begin
      state_q        <= state_d;
      gap_q          <= (state_q == ST_PIN) ? gap_q + 4'h1 : 4'h0;
      core_reset_n_q <= (state_d == ST_RUN) & ~any_src;            // [R25]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control and flag registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_brownout_enable  <= 1'b1;
      brownout_fast_start <= 1'b0;
      power_control_reg   <= `POWER_CONTROL_REG_POR_VAL;
      timeout_flag_n      <= 1'b1;
      powerdown_flag_n    <= 1'b1;
      pullup_q            <= 1'b0;
    end else begin
      if (wr_boc) begin
        sw_brownout_enable  <= hwdata[`BOC_SW_ENABLE_BIT];        // [R7]
        brownout_fast_start <= hwdata[`BOC_FAST_START_BIT];
      end
      if (wr_misc) pullup_q <= hwdata[`MISC_PULLUP_BIT];
      if (wr_stat) begin
        timeout_flag_n   <= hwdata[`STAT_TO_BIT];
        powerdown_flag_n <= hwdata[`STAT_PD_BIT];
      end
      if (wr_power_control_reg) power_control_reg <= hwdata[7:0] & 8'hdf;      // [R24]
      // Hardware events win over software writes
      if (por_any) begin
        power_control_reg <= `POWER_CONTROL_REG_POR_VAL & 8'hfd;               // [R22] [R19]
        timeout_flag_n    <= 1'b1;
        powerdown_flag_n  <= 1'b1;
      end else begin
        if (bor_trip | lp_trip) begin
          power_control_reg[7:6]           <= 2'b00;              // [R22]
          power_control_reg[`POWER_CONTROL_REG_PIN_BIT] <= 1'b1;
          power_control_reg[`POWER_CONTROL_REG_RI_BIT]  <= 1'b1;
          power_control_reg[`POWER_CONTROL_REG_BOR_BIT] <= 1'b0;               // [R10]
          timeout_flag_n                   <= 1'b1;
          powerdown_flag_n                 <= 1'b1;
        end
        if (wdt_s) begin
          power_control_reg[`POWER_CONTROL_REG_WDT_BIT] <= 1'b0;               // [R16]
          timeout_flag_n                   <= 1'b0;
          if (sleep_s) powerdown_flag_n <= 1'b0;
        end
        if (pin_hold) begin
          power_control_reg[`POWER_CONTROL_REG_PIN_BIT] <= 1'b0;
          if (sleep_s) begin
            timeout_flag_n   <= 1'b1;
            powerdown_flag_n <= 1'b0;
          end
        end
        if (ri_s) power_control_reg[`POWER_CONTROL_REG_RI_BIT] <= 1'b0;        // [R17]
        if (stack_err_reset_enable & ovf_s)
          power_control_reg[`POWER_CONTROL_REG_STACK_OVERFLOW_FLAG_BIT] <= 1'b1;            // [R18]
        if (stack_err_reset_enable & unf_s)
          power_control_reg[`POWER_CONTROL_REG_STACK_UNDERFLOW_FLAG_BIT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_ok_q         <= 1'b0;
      detector_enable_q <= 1'b0;
      bandgap_force_q   <= 1'b0;
      pin_pullup_q      <= 1'b1;
      ext_reset_pin_out <= 1'b1;
      ext_reset_pin_oe  <= 1'b0;
      gp_input_q        <= 1'b1;
      pc_reset_value    <= 14'h0000;
    end else begin
      wake_ok_q         <= wake_s & ~(mode_nosl & ~rdy_s);        // [R2] [R4]
      detector_enable_q <= det_en;
      bandgap_force_q   <= brownout_fast_start & (mode_nosl | mode_sw); // [R8]
      pin_pullup_q      <= pin_en | pullup_q;                      // [R15]
      ext_reset_pin_out <= 1'b1;                                   // [R14]
      ext_reset_pin_oe  <= 1'b0;                                   // [R14]
      gp_input_q        <= pin_en ? 1'b1 : pin_s;                  // [R15]
      pc_reset_value    <= 14'h0000;                               // [R22]
    end
  end
endmodule // reset_source_sequencer

// ---- bench/reset_seq_asserts.sv ----
// Port checker for the reset sequencer
// Assumes bind onto reset_source_sequencer
`timescale 1ns/100ps
module reset_seq_asserts (
  input wire        hclk,
  input wire        hresetn,
  input wire [1:0]  brownout_mode_sel,
  input wire        ext_reset_pin_enable,
  input wire        low_voltage_prog,
  input wire        ext_reset_pin_in,
  input wire        watchdog_timeout,
  input wire        reset_instr,
  input wire        core_reset_n_q,
  input wire        detector_enable_q,
  input wire        bandgap_force_q,
  input wire        ext_reset_pin_oe,
  input wire        gp_input_q,
  input wire [13:0] pc_reset_value
);
  wire pin_on = ext_reset_pin_enable | low_voltage_prog;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////
  chk_pin_undriven: assert property (!ext_reset_pin_oe)
    else $error("reset pin driven");
  chk_pc_restart: assert property (pc_reset_value == 14'h0000)
    else $error("restart address not zero");
  chk_pin_holds: assert property (pin_on && !ext_reset_pin_in [*8] |=> !core_reset_n_q)
    else $error("pin low did not hold reset");
  chk_pin_gap: assert property ($rose(core_reset_n_q) && pin_on |-> $past(ext_reset_pin_in, 10))
    else $error("start too soon after pin release");
  chk_mode_on: assert property (brownout_mode_sel == 2'h3 [*3] |-> detector_enable_q)
    else $error("detector off in always-on mode");
  chk_mode_off: assert property (brownout_mode_sel == 2'h0 [*3] |-> !detector_enable_q)
    else $error("detector on in off mode");
  chk_bandgap_idle: assert property (brownout_mode_sel[1] == brownout_mode_sel[0] [*3]
    |-> !bandgap_force_q) else $error("band gap forced in mode 11 or 00");
  chk_wdt_resets: assert property ($rose(watchdog_timeout) && core_reset_n_q
    |-> ##[1:8] !core_reset_n_q) else $error("watchdog gave no reset");
  chk_instr_resets: assert property ($rose(reset_instr) && core_reset_n_q
    |-> ##[1:8] !core_reset_n_q) else $error("reset instruction ignored");
  chk_gp_idle: assert property (pin_on [*4] |-> gp_input_q)
    else $error("general input not idle");
  cover property ($rose(core_reset_n_q));
  cover property ($rose(watchdog_timeout) && core_reset_n_q);
  cover property (pin_on && !ext_reset_pin_in [*8]);
endmodule // reset_seq_asserts

bind reset_source_sequencer reset_seq_asserts reset_seq_asserts_i (.*);

// ---- bench/ext_pin_model.sv ----
// Far side of the reset pin: a button or driver with weak pull-up
// Assumes hold_low comes from the bench
`timescale 1ns/100ps
module ext_pin_model (
  input  wire hold_low,
  input  wire pin_oe,
  input  wire pin_out,
  output wire pin
);
  // Pulled up unless the button or the device pulls low
  assign pin = (hold_low || (pin_oe && !pin_out)) ? 1'b0 : 1'b1;
endmodule // ext_pin_model

// ---- bench/tb_top.sv ----
// Self-checking bench for the reset sequencer
// Assumes reset_seq_map.vh on the include path
`timescale 1ns/100ps
`include "reset_seq_map.vh"
module tb_top;
  localparam POWERUP_TIMER = 50;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, hold_low;
  logic [11:0] haddr;
  logic [1:0]  htrans, brownout_mode_sel;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic low_power_brownout, ext_reset_pin_enable, low_voltage_prog, powerup_timer_enable_n;
  logic stack_err_reset_enable, por_event, vdd_low, lp_vdd_low, detector_ready;
  logic ext_reset_pin_in, sleep_mode, wake_request, watchdog_timeout, reset_instr;
  logic stack_overflow, stack_underflow, prog_mode_exit, core_reset_n_q, wake_ok_q;
  logic detector_enable_q, bandgap_force_q, pin_pullup_q, ext_reset_pin_out, ext_reset_pin_oe;
  logic        gp_input_q;
  logic [13:0] pc_reset_value;
  int          err_total, checks, n;
  logic [7:0]  exp_power_control_reg [7] = '{8'h0f, 8'h1b, 8'h9f, 8'h5f, 8'h17, 8'h1e, 8'h1e};

  reset_source_sequencer #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER)) reset_source_sequencer_i (.*);
  ext_pin_model ext_pin_model_i (.hold_low(hold_low), .pin_oe(ext_reset_pin_oe),
    .pin_out(ext_reset_pin_out), .pin(ext_reset_pin_in));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task wait_core;
    n = 0;
    while (core_reset_n_q !== 1'b1 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 3000) chk(32'h0, 32'h1);
  endtask
  task src(input int k, input logic v);
    case (k)
      0: watchdog_timeout <= v;
      1: reset_instr <= v;
      2: stack_overflow <= v;
      3: stack_underflow <= v;
      4: hold_low <= v;
      5: vdd_low <= v;
      6: lp_vdd_low <= v;
      7: por_event <= v;
      default: prog_mode_exit <= v;
    endcase
  endtask
  task pulse(input int k, input int len);
    src(k, 1'b1);
    repeat (len) @(posedge hclk);
    src(k, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_power_on;
    for (int k = 7; k < 9; k++) begin
      pulse(k, 4);
      wait_core;
      chk(n >= POWERUP_TIMER, 1);
      ahb(0, `POWER_CONTROL_REG_OFS, 0);
      chk(rd & 32'hfe, 32'h1c);
      ahb(0, `STATUS_FLAGS_REG_OFS, 0);
      chk(rd & 32'h3, 32'h3);
      hold_low <= 1'b1;
      pulse(k, 4);
      repeat (POWERUP_TIMER + 40) @(posedge hclk);
      chk(core_reset_n_q, 0);
      hold_low <= 1'b0;
      wait_core;
      chk(n >= 10 && n <= 22, 1);
    end
    $display("t_power_on done");
  endtask
  task t_causes;
    for (int k = 0; k < 7; k++) begin
      ahb(1, `POWER_CONTROL_REG_OFS, 32'h1f);
      if (k == 6) begin
        brownout_mode_sel <= 2'h0;
        low_power_brownout <= 1'b1;
      end
      pulse(k, 20);
      wait_core;
      ahb(0, `POWER_CONTROL_REG_OFS, 0);
      chk(rd, exp_power_control_reg[k]);
      if (k == 0) ahb(0, `STATUS_FLAGS_REG_OFS, 0);
      if (k == 0) chk(rd[1], 0);
    end
    brownout_mode_sel <= 2'h3;
    stack_err_reset_enable <= 1'b0;
    pulse(2, 20);
    pulse(4, 2);
    repeat (20) @(posedge hclk);
    chk(core_reset_n_q, 1);
    $display("t_causes done");
  endtask
  task t_control;
    brownout_mode_sel <= 2'h1;
    ahb(1, `BROWNOUT_CONTROL_REG_OFS, 32'h0);
    repeat (4) @(posedge hclk);
    chk({detector_enable_q, bandgap_force_q}, 0);
    ahb(1, `BROWNOUT_CONTROL_REG_OFS, 32'hff);
    ahb(0, `BROWNOUT_CONTROL_REG_OFS, 0);
    chk(rd, 32'hc1);
    chk({detector_enable_q, bandgap_force_q}, 3);
    brownout_mode_sel <= 2'h2;
    sleep_mode <= 1'b1;
    repeat (4) @(posedge hclk);
    chk(detector_enable_q, 0);
    brownout_mode_sel <= 2'h3;
    repeat (4) @(posedge hclk);
    chk(detector_enable_q, 1);
    sleep_mode <= 1'b0;
    ahb(0, 12'h010, 0);
    chk(rd, 0);
    ext_reset_pin_enable <= 1'b0;
    ahb(1, `MISC_CONTROL_REG_OFS, 32'h0);
    hold_low <= 1'b1;
    repeat (20) @(posedge hclk);
    chk({pin_pullup_q, gp_input_q, core_reset_n_q}, 1);
    hold_low <= 1'b0;
    chk({hresp, ext_reset_pin_oe, pc_reset_value}, 0);
    brownout_mode_sel <= 2'h2;
    wake_request <= 1'b1;
    detector_ready <= 1'b0;
    repeat (4) @(posedge hclk);
    chk(wake_ok_q, 0);
    brownout_mode_sel <= 2'h3;
    repeat (4) @(posedge hclk);
    chk(wake_ok_q, 1);
    detector_ready <= 1'b1;
    wake_request <= 1'b0;
    $display("t_control done");
  endtask
  task test_done;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    {hsel, hwrite, hold_low, haddr, htrans, hwdata, hresetn} = '0;
    {por_event, vdd_low, lp_vdd_low, sleep_mode, wake_request, watchdog_timeout} = '0;
    {reset_instr, stack_overflow, stack_underflow, prog_mode_exit} = '0;
    {low_power_brownout, low_voltage_prog, powerup_timer_enable_n} = '0;
    {hready, detector_ready, ext_reset_pin_enable, stack_err_reset_enable} = '1;
    hsize = 3'h2;
    brownout_mode_sel = 2'h3;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    wait_core;
    t_power_on;
    t_causes;
    t_control;
    test_done;
  end
  initial begin
    #200000;
    err_total++;
    test_done;
  end
endmodule // tb_top
